// file: hw/gdp_map.svh
// register map, field layout, reset values and spi framing of the pin block
`ifndef GDP_MAP_SVH
`define GDP_MAP_SVH

// ----------------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------------
`define GDP_IDX_FUNC_EN    4'hc
`define GDP_IDX_DIR        4'hd
`define GDP_IDX_LEVEL      4'he
`define GDP_ADDR_FUNC_EN   12'h030
`define GDP_ADDR_DIR       12'h034
`define GDP_ADDR_LEVEL     12'h038

// ----------------------------------------------------------------------------
// reset values and field layout
// ----------------------------------------------------------------------------
`define GDP_RST_FUNC_EN    8'h00
`define GDP_RST_DIR        8'h00
`define GDP_RST_LEVEL      8'h00
`define GDP_PINS           8
`define GDP_DIR_INPUT      1'b1
`define GDP_CMD_WR_BIT     7
`define GDP_CMD_IDX_MSB    3

// ----------------------------------------------------------------------------
// serial framing
// ----------------------------------------------------------------------------
`define GDP_BIT_LAST       3'h7

`endif

// file: hw/gdp_pkg.sv
// types shared by the pin block modules
package gdp_pkg;

  typedef enum logic [1:0] {
    SP_CMD,
    SP_DATA,
    SP_DONE
  } gdp_spi_e;

  typedef logic [7:0] gdp_byte_t;

endpackage

// file: hw/gdp_spi_slave.sv
// mode 1 serial byte shifter, serial pins sampled on the core clock
`timescale 1ns/100ps
`include "gdp_map.svh"
module gdp_spi_slave (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            cs_n_i,
  input  wire logic            sclk_i,
  input  wire logic            mosi_i,
  input  wire gdp_pkg::gdp_byte_t tx_byte_i,
  input  wire logic            tx_load_i,
  output gdp_pkg::gdp_byte_t   rx_byte_o,
  output logic                 rx_valid_o,
  output logic                 miso_o
);

  typedef struct packed {
    logic               sclk_d;
    logic [2:0]         bit_cnt;
    gdp_pkg::gdp_byte_t rx_sh;
    gdp_pkg::gdp_byte_t tx_sh;
    logic               miso;
    logic               rx_valid;
  } gdp_spi_s;

  gdp_spi_s st_reg;
  gdp_spi_s st_next;
  logic     rise;
  logic     fall;

  assign rise = sclk_i & ~st_reg.sclk_d;
  assign fall = ~sclk_i & st_reg.sclk_d;

  always_comb
  begin
    st_next          = st_reg;
    st_next.sclk_d   = sclk_i;
    st_next.rx_valid = 1'b0;
    if (cs_n_i)
    begin
      // frame ends: realign to byte start
      st_next.bit_cnt = 3'h0;
      st_next.miso    = 1'b0;
    end
    else
    begin
      if (rise)
      begin
        st_next.miso  = st_reg.tx_sh[7];
        st_next.tx_sh = {st_reg.tx_sh[6:0], 1'b0};
      end
      if (fall)
      begin
        st_next.rx_sh   = {st_reg.rx_sh[6:0], mosi_i};
        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
        if (st_reg.bit_cnt == `GDP_BIT_LAST)
          st_next.rx_valid = 1'b1;
      end
    end
    if (tx_load_i)
      st_next.tx_sh = tx_byte_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign rx_byte_o  = st_reg.rx_sh;
  assign rx_valid_o = st_reg.rx_valid;
  assign miso_o     = st_reg.miso;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_miso_rising_only:
    assert property ($changed(miso_o) |-> $past(rise) || $past(cs_n_i))
    else $error("serial output changed outside a rising clock edge");

  a_capture_on_fall:
    assert property (rx_valid_o |-> $past(fall) && !$past(cs_n_i)
                     && rx_byte_o[0] == $past(mosi_i))
    else $error("byte completed without a falling edge capture");

  c_byte_done: cover property (rx_valid_o);

endmodule

// file: hw/gdp_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/100ps
module gdp_sync2 #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } gdp_sync_s;

  gdp_sync_s st_reg;
  gdp_sync_s st_next;

  // first stage feeds only the second stage
  always_comb
  begin
    st_next.meta = d_i;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q_o = st_reg.sync;

endmodule

// file: hw/gdp_top.sv
// shared pin level port: apb slave, mode 1 serial access, pin drivers
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "gdp_map.svh"
module gdp_top (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        SPI_CS_N_I,
  input  wire logic        SPI_SCLK_I,
  input  wire logic        SPI_MOSI_I,
  output logic             SPI_MISO_O,
  output logic             SPI_MISO_OE_O,
  input  wire logic [7:0]  PIN_I,
  output logic      [7:0]  PIN_O,
  output logic      [7:0]  PIN_OE_O
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    gdp_pkg::gdp_byte_t pin_function_enable_bits;
    gdp_pkg::gdp_byte_t pin_direction_bits;
    gdp_pkg::gdp_byte_t pin_level_bits;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    gdp_pkg::gdp_spi_e  spi_st;
    logic               spi_wr;
    logic [3:0]         spi_idx;
    logic               miso_oe;
    gdp_pkg::gdp_byte_t pin_out;
    gdp_pkg::gdp_byte_t pin_oe;
  } gdp_top_s;

  gdp_top_s           st_reg;
  gdp_top_s           st_next;
  gdp_pkg::gdp_byte_t pin_sync;
  gdp_pkg::gdp_byte_t rx_byte;
  logic               rx_valid;
  logic               spi_miso;
  gdp_pkg::gdp_byte_t tx_byte;
  logic               tx_load;
  logic               apb_setup;
  logic               apb_done;

  // --------------------------------------------------------------------------
  // submodules
  // --------------------------------------------------------------------------
  gdp_sync2 #(
    .W (`GDP_PINS)
  ) u_pin_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RESET_N_I),
    .d_i     (PIN_I),
    .q_o     (pin_sync)
  );

  gdp_spi_slave u_spi (
    .clk_i      (CORE_CLK_I),
    .rst_n_i    (RESET_N_I),
    .cs_n_i     (SPI_CS_N_I),
    .sclk_i     (SPI_SCLK_I),
    .mosi_i     (SPI_MOSI_I),
    .tx_byte_i  (tx_byte),
    .tx_load_i  (tx_load),
    .rx_byte_o  (rx_byte),
    .rx_valid_o (rx_valid),
    .miso_o     (spi_miso)
  );

  // --------------------------------------------------------------------------
  // read value of a register index
  // --------------------------------------------------------------------------
  function automatic gdp_pkg::gdp_byte_t read_idx(
    input logic [3:0]         idx,
    input gdp_top_s           s,
    input gdp_pkg::gdp_byte_t pins
  );
    gdp_pkg::gdp_byte_t live_in;
    live_in = s.pin_function_enable_bits & s.pin_direction_bits;
    case (idx)
      `GDP_IDX_FUNC_EN: read_idx = s.pin_function_enable_bits;
      `GDP_IDX_DIR:     read_idx = s.pin_direction_bits;
      // outputs read the stored bit, enabled inputs the pin
      `GDP_IDX_LEVEL:   read_idx = (s.pin_level_bits & ~live_in)
                                 | (pins & live_in);
      default:          read_idx = 8'h00;
    endcase
  endfunction

  function automatic logic [3:0] apb_idx(input logic [11:0] addr);
    case (addr)
      `GDP_ADDR_FUNC_EN: apb_idx = `GDP_IDX_FUNC_EN;
      `GDP_ADDR_DIR:     apb_idx = `GDP_IDX_DIR;
      `GDP_ADDR_LEVEL:   apb_idx = `GDP_IDX_LEVEL;
      default:           apb_idx = 4'h0;
    endcase
  endfunction

  assign apb_setup = PSEL_I & ~PENABLE_I;
  assign apb_done  = PSEL_I & PENABLE_I & st_reg.pready;
  assign tx_load   = rx_valid & (st_reg.spi_st == gdp_pkg::SP_CMD);
  assign tx_byte   = read_idx(rx_byte[`GDP_CMD_IDX_MSB:0], st_reg, pin_sync);

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic [3:0]         widx;
    gdp_pkg::gdp_byte_t wdat;
    logic               wen;
    widx    = 4'h0;
    wdat    = 8'h00;
    wen     = 1'b0;
    st_next = st_reg;

    // apb: answer prepared in setup, ready in first access cycle
    st_next.pready = apb_setup;
    if (apb_setup)
    begin
      st_next.pslverr = (apb_idx(PADDR_I) == 4'h0);
      st_next.prdata  = {24'h000000,
                         read_idx(apb_idx(PADDR_I), st_reg, pin_sync)};
    end
    else if (apb_done)
    begin
      st_next.pslverr = 1'b0;
      st_next.prdata  = 32'h00000000;
    end

    // serial: command byte, then one data byte per frame
    case (st_reg.spi_st)
      gdp_pkg::SP_CMD:
      begin
        if (rx_valid)
        begin
          st_next.spi_wr  = rx_byte[`GDP_CMD_WR_BIT];
          st_next.spi_idx = rx_byte[`GDP_CMD_IDX_MSB:0];
          st_next.spi_st  = gdp_pkg::SP_DATA;
        end
      end
      gdp_pkg::SP_DATA:
      begin
        if (rx_valid)
          st_next.spi_st = gdp_pkg::SP_DONE;
      end
      gdp_pkg::SP_DONE:
        st_next.spi_st = gdp_pkg::SP_DONE;
      default:
        st_next.spi_st = gdp_pkg::SP_CMD;
    endcase
    if (SPI_CS_N_I)
      st_next.spi_st = gdp_pkg::SP_CMD;
    st_next.miso_oe = ~SPI_CS_N_I;

    // register writes; apb wins over a serial write in the same cycle
    if (rx_valid && st_reg.spi_st == gdp_pkg::SP_DATA && st_reg.spi_wr)
    begin
      wen  = 1'b1;
      widx = st_reg.spi_idx;
      wdat = rx_byte;
    end
    if (apb_done && PWRITE_I && !st_reg.pslverr)
    begin
      wen  = 1'b1;
      widx = apb_idx(PADDR_I);
      wdat = PWDATA_I[7:0];
    end
    if (wen)
    begin
      case (widx)
        `GDP_IDX_FUNC_EN: st_next.pin_function_enable_bits = wdat;
        `GDP_IDX_DIR:     st_next.pin_direction_bits = wdat;
        `GDP_IDX_LEVEL:   st_next.pin_level_bits = wdat;
        default:          st_next.pin_level_bits = st_reg.pin_level_bits;
      endcase
    end

    // drive only enabled output pins; inputs just store
    st_next.pin_out = st_next.pin_level_bits;
    st_next.pin_oe  = st_next.pin_function_enable_bits
                    & ~st_next.pin_direction_bits;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RESET_N_I)
    begin
      st_reg                          <= '0;
      st_reg.pin_function_enable_bits <= `GDP_RST_FUNC_EN;
      st_reg.pin_direction_bits       <= `GDP_RST_DIR;
      st_reg.pin_level_bits           <= `GDP_RST_LEVEL;
      st_reg.spi_st                   <= gdp_pkg::SP_CMD;
    end
    else
      st_reg <= st_next;
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign PRDATA_O      = st_reg.prdata;
  assign PREADY_O      = st_reg.pready;
  assign PSLVERR_O     = st_reg.pslverr;
  assign SPI_MISO_O    = spi_miso;
  assign SPI_MISO_OE_O = st_reg.miso_oe;
  assign PIN_O         = st_reg.pin_out;
  assign PIN_OE_O      = st_reg.pin_oe;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  logic rd_level;
  assign rd_level = PSEL_I & PENABLE_I & PREADY_O & ~PWRITE_I
                  & (PADDR_I == `GDP_ADDR_LEVEL);

  a_level_reset_zero:
    assert property (disable iff (1'b0)
      !RESET_N_I |=> st_reg.pin_level_bits == 8'h00 && PIN_O == 8'h00)
    else $error("level register not cleared by reset");

  a_pin_follows_level:
    assert property (PIN_O == st_reg.pin_level_bits)
    else $error("pin output differs from stored level");

  a_output_reads_reg:
    assert property (rd_level |-> ((PRDATA_O[7:0]
      ^ $past(st_reg.pin_level_bits))
      & ~$past(st_reg.pin_function_enable_bits
      & st_reg.pin_direction_bits)) == 8'h00)
    else $error("output pin read did not return stored value");

  a_input_reads_pin:
    assert property (rd_level |-> ((PRDATA_O[7:0] ^ $past(pin_sync))
      & $past(st_reg.pin_function_enable_bits
      & st_reg.pin_direction_bits)) == 8'h00)
    else $error("enabled input read did not return pin level");

  a_input_never_driven:
    assert property ((PIN_OE_O & st_reg.pin_direction_bits) == 8'h00)
    else $error("input pin is being driven");

  a_oe_needs_enable:
    assert property ((PIN_OE_O & ~st_reg.pin_function_enable_bits) == 8'h00)
    else $error("pin driven without function enable");

  a_dir_write_oe:
    assert property (apb_done && PWRITE_I && PADDR_I == `GDP_ADDR_DIR
      |=> PIN_OE_O == (st_reg.pin_function_enable_bits
                       & ~$past(PWDATA_I[7:0])))
    else $error("direction write did not steer the drivers");

  a_apb_ready_one:
    assert property (apb_setup |=> PREADY_O ##1 !PREADY_O)
    else $error("apb answer not one cycle after setup");

  a_unmapped_error:
    assert property (apb_setup && PADDR_I != `GDP_ADDR_FUNC_EN
      && PADDR_I != `GDP_ADDR_DIR && PADDR_I != `GDP_ADDR_LEVEL
      |=> PREADY_O && PSLVERR_O && PRDATA_O == 32'h00000000)
    else $error("unmapped access not refused");

  a_apb_level_write:
    assert property (apb_done && PWRITE_I && PADDR_I == `GDP_ADDR_LEVEL
      |=> st_reg.pin_level_bits == $past(PWDATA_I[7:0]))
    else $error("bus write did not reach the level register");

  // a bus write in the same cycle takes the port, so leave it out here
  a_spi_level_write:
    assert property (rx_valid && st_reg.spi_st == gdp_pkg::SP_DATA
      && st_reg.spi_wr && st_reg.spi_idx == `GDP_IDX_LEVEL
      && !(apb_done && PWRITE_I)
      |=> st_reg.pin_level_bits == $past(rx_byte))
    else $error("serial write did not reach the level register");

  // only a bus write or a serial data byte may move the stored levels
  a_level_held:
    assert property (!(apb_done && PWRITE_I) && !(rx_valid
      && st_reg.spi_st == gdp_pkg::SP_DATA && st_reg.spi_wr)
      |=> $stable(st_reg.pin_level_bits))
    else $error("level register changed without a write");

  c_level_write: cover property (apb_done && PWRITE_I
                                 && PADDR_I == `GDP_ADDR_LEVEL);
  c_input_read:  cover property (rd_level
                                 && st_reg.pin_direction_bits != 8'h00);
  c_spi_read:    cover property (tx_load
                   && rx_byte[`GDP_CMD_IDX_MSB:0] == `GDP_IDX_LEVEL);
  c_spi_write:   cover property (rx_valid && st_reg.spi_wr
                                 && st_reg.spi_st == gdp_pkg::SP_DATA);

endmodule

// file: testbench/gdp_spi_master.sv
// serial master model: two-byte mode 1 frames
`timescale 1ns/100ps
module gdp_spi_master (
  input  wire logic       clk_i,
  input  wire logic       miso_i,
  output logic            cs_n_o,
  output logic            sclk_o,
  output logic            mosi_o,
  output logic [7:0]      rx_o,
  output logic            done_o
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    rx_o = 8'h00;
    done_o = 1'b0;
  end

  // ---------------------------------------------------------------------
  // frame task
  // ---------------------------------------------------------------------
  // half: core cycles per clock half, 2 at least or the core's miso bit comes too late for the master
  task automatic frame(input logic [15:0] tx, input int half);
    logic [15:0] rx;
    rx = 16'h0000;
    cs_n_o <= 1'b0;
    repeat (half) @(posedge clk_i);
    for (int i = 15; i >= 0; i--)
    begin
      sclk_o <= 1'b1;
      mosi_o <= tx[i];
      repeat (half) @(posedge clk_i);
      sclk_o <= 1'b0;
      rx[i] = miso_i;
      repeat (half) @(posedge clk_i);
    end
    cs_n_o <= 1'b1;
    // released line: no stale bit left for the core to trust
    mosi_o <= ~mosi_o;
    rx_o <= rx[7:0];
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
    repeat (half) @(posedge clk_i);
  endtask
endmodule

// file: testbench/tb_top.sv
// self-checking bench of the shared pin level port
`timescale 1ns/100ps
`include "gdp_map.svh"
module tb_top;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        cs_n, sclk, mosi, miso, miso_oe, spi_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  pin_in, pin_out, pin_oe, spi_rx, en, dir, lv, pv;
  logic [32:0] apb_q[$];
  logic [7:0]  spi_q[$];
  logic        wr_q[$];
  int          n_errors, tests_run;

  gdp_top u_gdp_top (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SPI_CS_N_I(cs_n), .SPI_SCLK_I(sclk),
    .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_O(miso_oe),
    .PIN_I(pin_in), .PIN_O(pin_out), .PIN_OE_O(pin_oe));
  gdp_spi_master u_gdp_spi_master (.clk_i(clk), .miso_i(miso),
    .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .rx_o(spi_rx),
    .done_o(spi_done));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // ---------------------------------------------------------------------
  // compare, bus tasks, monitor
  // ---------------------------------------------------------------------
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
  endtask

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    wr_q.push_back(!(a inside {`GDP_ADDR_FUNC_EN, `GDP_ADDR_DIR,
                               `GDP_ADDR_LEVEL}));
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input logic err);
    apb_q.push_back({err, 24'h0, e});
    apb(1'b0, a, 32'h0);
  endtask

  // results are matched in issue order, whatever their latency
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0)
      chk(apb_q.pop_front(), {pslverr, prdata});
    if (psel && penable && pready === 1'b1 && pwrite === 1'b1)
      chk({32'h0, wr_q.pop_front()}, {32'h0, pslverr});
    if (spi_done === 1'b1)
      chk({25'h0, spi_q.pop_front()}, {25'h0, spi_rx});
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pin_in} = '0;
    n_errors = 0;
    tests_run = 0;
    void'($urandom(32'h3723));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(33'h0, {16'h0, pin_out, pin_oe, miso_oe});
    rd(`GDP_ADDR_FUNC_EN, `GDP_RST_FUNC_EN, 1'b0);
    rd(`GDP_ADDR_DIR, `GDP_RST_DIR, 1'b0);
    rd(`GDP_ADDR_LEVEL, `GDP_RST_LEVEL, 1'b0);
    wr(12'h03c, 8'hff);
    rd(12'h03c, 8'h00, 1'b1);
    rd(`GDP_ADDR_LEVEL, 8'h00, 1'b0);
    idle();
    $display("test reset done");
    for (int k = 0; k < 6; k++)
    begin
      en = (k < 2) ? 8'hff : 8'($urandom);
      dir = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      lv = 8'($urandom);
      pv = 8'($urandom);
      pin_in <= pv;
      wr(`GDP_ADDR_FUNC_EN, en);
      wr(`GDP_ADDR_DIR, dir);
      wr(`GDP_ADDR_LEVEL, lv);
      idle();
      repeat (3) @(posedge clk);
      chk({17'h0, lv, en & ~dir}, {17'h0, pin_out, pin_oe});
      rd(`GDP_ADDR_LEVEL, (en & dir & pv) | (~(en & dir) & lv),
         1'b0);
      rd(`GDP_ADDR_DIR, dir, 1'b0);
      rd(`GDP_ADDR_FUNC_EN, en, 1'b0);
      idle();
    end
    $display("test pin roles done");
    wr(`GDP_ADDR_DIR, 8'h00);
    idle();
    // a write frame still shifts out the value held before it
    spi_q.push_back(lv);
    lv = 8'($urandom);
    u_gdp_spi_master.frame({1'b1, 3'h0, `GDP_IDX_LEVEL, lv}, 6);
    rd(`GDP_ADDR_LEVEL, lv, 1'b0);
    en = 8'($urandom);
    wr(`GDP_ADDR_FUNC_EN, en);
    idle();
    spi_q.push_back(en);
    u_gdp_spi_master.frame({4'h0, `GDP_IDX_FUNC_EN, 8'h00}, 11);
    spi_q.push_back(lv);
    u_gdp_spi_master.frame({4'h0, `GDP_IDX_LEVEL, 8'h00}, 4);
    spi_q.push_back(8'h00);
    u_gdp_spi_master.frame({8'h03, 8'h00}, 6);
    chk(33'h0, {32'h0, miso_oe});
    spi_q.push_back(8'h00);
    dir = 8'($urandom);
    u_gdp_spi_master.frame({1'b1, 3'h0, `GDP_IDX_DIR, dir}, 5);
    rd(`GDP_ADDR_DIR, dir, 1'b0);
    idle();
    $display("test serial done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`GDP_ADDR_LEVEL, 8'h00, 1'b0);
    idle();
    repeat (2) @(posedge clk);
    chk(33'h0, 33'(apb_q.size() + spi_q.size() + wr_q.size()));
    $display("test second reset done");
    end_of_test();
  end
endmodule
